// File: logic/pomg_port.sv
// Top of the port one multiplexed GPIO block.
// Notes on behaviour
// - Direction bit one makes a pin output; function zero drives the latch value.
// - A plain data read returns the sampled pin levels.
// - Read-modify-write reads of the data register return the latch contents.
// - Pin levels read back for every bit whatever the direction.
// - Pull-up on only for direction zero with latch one.
// - Input floats with latch zero and is pulled up with latch one; output drives its level low or high, high floats when open-drain.
// - Bit 7 merged value is PWM high AND buzzer, XOR latch.
// - Bit 6 merged value is PWM low XOR latch.
// - Bit 5 merged value is serial one clock OR latch.
// - Bits 4 and 3 carry serial one data OR their latch bit.
// - Bit 2 merged value is serial zero clock OR latch.
// - Bits 1 and 0 carry serial zero data OR their latch bit.
// - Active serial one receives from pin 4 regardless of direction.
// - Active serial zero receives from pin 1 regardless of direction.
// - Open-drain bits release the pin for any high output.
// - In low-power modes every pin holds its entry state.
// - Function bits act only on output bits.
`timescale 1ns/1ns
module pomg_port #(
    parameter int           WIDTH          = 8,
    parameter logic [7:0]   OPEN_DRAIN_OPT = 8'h00
) (
    input  wire logic                   clk,
    input  wire logic                   rst,
    input  wire pomg_pkg::pomg_bus_req_s bus_req,
    output logic [7:0]                  bus_rdata_q,
    output logic                        bus_rvalid_q,
    input  wire pomg_pkg::pomg_periph_s periph,
    output pomg_pkg::pomg_periph_in_s   periph_in_q,
    input  wire logic                   low_power,
    input  wire logic [WIDTH-1:0]       pin_in,
    output logic      [WIDTH-1:0]       pin_out_q,
    output logic      [WIDTH-1:0]       pin_oe_q,
    output logic      [WIDTH-1:0]       pull_up_q
);
    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [WIDTH-1:0] latch_q;
    logic [WIDTH-1:0] latch_d;
    logic [WIDTH-1:0] dir_q;
    logic [WIDTH-1:0] dir_d;
    logic [WIDTH-1:0] func_q;
    logic [WIDTH-1:0] func_d;
    logic [7:0]       test_q;
    logic [7:0]       test_d;
    logic [7:0]       rdata_d;
    logic             rvalid_d;
    logic [WIDTH-1:0] pin_level;
    pomg_pkg::pomg_access_e acc;

    pomg_pin_sync #(
        .WIDTH (WIDTH)
    ) u_sync (
        .clk      (clk),
        .rst      (rst),
        .async_in (pin_in),
        .level_q  (pin_level)
    );

    always_comb begin
        if (!bus_req.req) begin
            acc = pomg_pkg::POMG_ACC_IDLE;
        end else if (bus_req.wr) begin
            acc = pomg_pkg::POMG_ACC_WRITE;
        end else if (bus_req.rmw) begin
            acc = pomg_pkg::POMG_ACC_RMW_READ;
        end else begin
            acc = pomg_pkg::POMG_ACC_READ;
        end
    end

    always_comb begin
        latch_d  = latch_q;
        dir_d    = dir_q;
        func_d   = func_q;
        test_d   = test_q;
        rdata_d  = bus_rdata_q;
        rvalid_d = 1'b0;
        unique case (acc)
            pomg_pkg::POMG_ACC_WRITE: begin
                unique case (bus_req.addr)
                    pomg_pkg::POMG_ADDR_DATA_LATCH: latch_d = bus_req.wdata[WIDTH-1:0];
                    pomg_pkg::POMG_ADDR_DIRECTION:  dir_d   = bus_req.wdata[WIDTH-1:0];
                    pomg_pkg::POMG_ADDR_FUNCTION:   func_d  = bus_req.wdata[WIDTH-1:0];
                    // Reserved bits are stored as written so a wrong write is visible. 
                    pomg_pkg::POMG_ADDR_TEST_MISC:  test_d  = bus_req.wdata & pomg_pkg::POMG_TEST_KEEP_MASK;
                    default: ;
                endcase
            end
            pomg_pkg::POMG_ACC_READ, pomg_pkg::POMG_ACC_RMW_READ: begin
                rvalid_d = 1'b1;
                unique case (bus_req.addr)
                    pomg_pkg::POMG_ADDR_DATA_LATCH: begin
                        if (acc == pomg_pkg::POMG_ACC_RMW_READ) begin
                            rdata_d = 8'(latch_q);
                        end else begin
                            rdata_d = 8'(pin_level);
                        end
                    end
                    pomg_pkg::POMG_ADDR_DIRECTION:  rdata_d = 8'(dir_q);
                    pomg_pkg::POMG_ADDR_FUNCTION:   rdata_d = 8'(func_q);
                    pomg_pkg::POMG_ADDR_TEST_MISC:  rdata_d = test_q | pomg_pkg::POMG_TEST_ONE_MASK;
                    default:                        rdata_d = 8'h00;
                endcase
            end
            pomg_pkg::POMG_ACC_IDLE: ;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            latch_q      <= WIDTH'(pomg_pkg::POMG_RST_DATA_LATCH);
            dir_q        <= WIDTH'(pomg_pkg::POMG_RST_DIRECTION);
            func_q       <= WIDTH'(pomg_pkg::POMG_RST_FUNCTION);
            test_q       <= pomg_pkg::POMG_RST_TEST_MISC;
            bus_rdata_q  <= 8'h00;
            bus_rvalid_q <= 1'b0;
        end else begin
            latch_q      <= latch_d;
            dir_q        <= dir_d;
            func_q       <= func_d;
            test_q       <= test_d;
            bus_rdata_q  <= rdata_d;
            bus_rvalid_q <= rvalid_d;
        end
    end

    // ------------------------------------------------------------
    // Peripheral merge
    // ------------------------------------------------------------
    logic [WIDTH-1:0] merged;
    logic [WIDTH-1:0] cell_out;
    logic [WIDTH-1:0] cell_oe;
    logic [WIDTH-1:0] cell_pu;

    always_comb begin
        merged = latch_q;
        merged[pomg_pkg::POMG_BIT_PWM_HIGH] = (periph.timer_one_high_pwm & periph.base_timer_buzzer)
                                            ^ latch_q[pomg_pkg::POMG_BIT_PWM_HIGH];
        merged[pomg_pkg::POMG_BIT_PWM_LOW]  = periph.timer_one_low_pwm
                                            ^ latch_q[pomg_pkg::POMG_BIT_PWM_LOW];
        merged[pomg_pkg::POMG_BIT_SU1_CLK]  = periph.serial_unit_one_clk
                                            | latch_q[pomg_pkg::POMG_BIT_SU1_CLK];
        merged[pomg_pkg::POMG_BIT_SU1_RX]   = periph.serial_unit_one_data
                                            | latch_q[pomg_pkg::POMG_BIT_SU1_RX];
        merged[pomg_pkg::POMG_BIT_SU1_DATA] = periph.serial_unit_one_data
                                            | latch_q[pomg_pkg::POMG_BIT_SU1_DATA];
        merged[pomg_pkg::POMG_BIT_SU0_CLK]  = periph.serial_unit_zero_clk
                                            | latch_q[pomg_pkg::POMG_BIT_SU0_CLK];
        merged[pomg_pkg::POMG_BIT_SU0_RX]   = periph.serial_unit_zero_data
                                            | latch_q[pomg_pkg::POMG_BIT_SU0_RX];
        merged[pomg_pkg::POMG_BIT_SU0_DATA] = periph.serial_unit_zero_data
                                            | latch_q[pomg_pkg::POMG_BIT_SU0_DATA];
    end

    generate
        for (genvar g = 0; g < WIDTH; g++) begin : g_cell
            pomg_bit_cell u_cell (
                .latch_bit    (latch_q[g]),
                .dir_bit      (dir_q[g]),
                .func_bit     (func_q[g]),
                .merged_value (merged[g]),
                .open_drain   (OPEN_DRAIN_OPT[g]),
                .pin_value    (cell_out[g]),
                .pin_oe       (cell_oe[g]),
                .pull_up      (cell_pu[g])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // Pin drivers
    // ------------------------------------------------------------
    // While in a low-power mode the pin registers simply stop loading, so
    // the state seen at entry is held for the whole mode.
    logic [WIDTH-1:0]          pin_out_d;
    logic [WIDTH-1:0]          pin_oe_d;
    logic [WIDTH-1:0]          pull_up_d;
    pomg_pkg::pomg_periph_in_s periph_in_d;

    always_comb begin
        pin_out_d   = low_power ? pin_out_q : cell_out;
        pin_oe_d    = low_power ? pin_oe_q  : cell_oe;
        pull_up_d   = low_power ? pull_up_q : cell_pu;
        periph_in_d = periph_in_q;
        if (periph.serial_unit_one_active) begin
            periph_in_d.serial_unit_one_rx = pin_level[pomg_pkg::POMG_BIT_SU1_RX];
        end
        if (periph.serial_unit_zero_active) begin
            periph_in_d.serial_unit_zero_rx = pin_level[pomg_pkg::POMG_BIT_SU0_RX];
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            pin_out_q   <= '0;
            pin_oe_q    <= '0;
            pull_up_q   <= '0;
            periph_in_q <= '0;
        end else begin
            pin_out_q   <= pin_out_d;
            pin_oe_q    <= pin_oe_d;
            pull_up_q   <= pull_up_d;
            periph_in_q <= periph_in_d;
        end
    end
endmodule // pomg_port

// File: logic/pomg_pkg.sv
// Package for the port one multiplexed GPIO block: offsets, reset values and carriers.
package pomg_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [15:0] POMG_ADDR_DATA_LATCH = 16'hfe44;
    localparam logic [15:0] POMG_ADDR_DIRECTION  = 16'hfe45;
    localparam logic [15:0] POMG_ADDR_FUNCTION   = 16'hfe46;
    localparam logic [15:0] POMG_ADDR_TEST_MISC  = 16'hfe47;

    localparam logic [7:0] POMG_RST_DATA_LATCH = 8'h00;
    localparam logic [7:0] POMG_RST_DIRECTION  = 8'h00;
    localparam logic [7:0] POMG_RST_FUNCTION   = 8'h00;
    localparam logic [7:0] POMG_RST_TEST_MISC  = 8'h00;
    // Test register bits kept here: only bits 7 and 0 (reserved) and bit 3 are stored.
    localparam logic [7:0] POMG_TEST_KEEP_MASK = 8'h89;
    // Bit 3 of the test register reads as one.
    localparam logic [7:0] POMG_TEST_ONE_MASK  = 8'h08;

    // ------------------------------------------------------------
    // Pin positions of the multiplexed functions
    // ------------------------------------------------------------
    localparam int POMG_BIT_PWM_HIGH  = 7;
    localparam int POMG_BIT_PWM_LOW   = 6;
    localparam int POMG_BIT_SU1_CLK   = 5;
    localparam int POMG_BIT_SU1_RX    = 4;
    localparam int POMG_BIT_SU1_DATA  = 3;
    localparam int POMG_BIT_SU0_CLK   = 2;
    localparam int POMG_BIT_SU0_RX    = 1;
    localparam int POMG_BIT_SU0_DATA  = 0;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        POMG_ACC_READ,
        POMG_ACC_WRITE,
        POMG_ACC_RMW_READ,
        POMG_ACC_IDLE
    } pomg_access_e;

    typedef struct packed {
        logic        req;
        logic        wr;
        logic        rmw;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } pomg_bus_req_s;

    typedef struct packed {
        logic timer_one_high_pwm;
        logic timer_one_low_pwm;
        logic base_timer_buzzer;
        logic serial_unit_one_clk;
        logic serial_unit_one_data;
        logic serial_unit_one_active;
        logic serial_unit_zero_clk;
        logic serial_unit_zero_data;
        logic serial_unit_zero_active;
    } pomg_periph_s;

    typedef struct packed {
        logic serial_unit_one_rx;
        logic serial_unit_zero_rx;
    } pomg_periph_in_s;

endpackage

// File: logic/pomg_pin_sync.sv
// Three-stage synchroniser for the port pins with agreement filter.
`timescale 1ns/1ns
module pomg_pin_sync #(
    parameter int WIDTH = 8
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] level_q
);
    logic [WIDTH-1:0] s1_q;
    logic [WIDTH-1:0] s2_q;
    logic [WIDTH-1:0] s3_q;
    logic [WIDTH-1:0] level_d;

    // A bit only changes once the second and third stages agree.
    always_comb begin
        for (int i = 0; i < WIDTH; i++) begin
            level_d[i] = (s2_q[i] == s3_q[i]) ? s2_q[i] : level_q[i];
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s1_q    <= '0;
            s2_q    <= '0;
            s3_q    <= '0;
            level_q <= '0;
        end else begin
            s1_q    <= async_in;
            s2_q    <= s1_q;
            s3_q    <= s2_q;
            level_q <= level_d;
        end
    end
endmodule // pomg_pin_sync

// File: logic/pomg_bit_cell.sv
// One port bit: output mux, drive enable and pull-up control.
`timescale 1ns/1ns
module pomg_bit_cell (
    input  wire logic latch_bit,
    input  wire logic dir_bit,
    input  wire logic func_bit,
    input  wire logic merged_value,
    input  wire logic open_drain,
    output logic      pin_value,
    output logic      pin_oe,
    output logic      pull_up
);
    logic level;

    always_comb begin
        level = func_bit ? merged_value : latch_bit;
        pin_value = level;
        pin_oe = dir_bit && !(open_drain && level);
        pull_up = !dir_bit && latch_bit;
    end
endmodule // pomg_bit_cell

// File: sim/pomg_port_props.sv
// Concurrent checks on the ports of the port one multiplexed GPIO block.
`timescale 1ns/1ns
module pomg_port_props #(
    parameter int         WIDTH          = 8,
    parameter logic [7:0] OPEN_DRAIN_OPT = 8'h00
) (
    input wire logic                       clk,
    input wire logic                       rst,
    input wire pomg_pkg::pomg_bus_req_s    bus_req,
    input wire logic [7:0]                 bus_rdata_q,
    input wire logic                       bus_rvalid_q,
    input wire pomg_pkg::pomg_periph_s     periph,
    input wire pomg_pkg::pomg_periph_in_s  periph_in_q,
    input wire logic                       low_power,
    input wire logic [WIDTH-1:0]           pin_in,
    input wire logic [WIDTH-1:0]           pin_out_q,
    input wire logic [WIDTH-1:0]           pin_oe_q,
    input wire logic [WIDTH-1:0]           pull_up_q
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // Shadow of the data latch, so read-modify-write answers can be judged without the design's state.
    logic [7:0] latch_q;
    logic [7:0] latch_d;
    logic       rd;
    assign rd = bus_req.req && !bus_req.wr;
    always_comb begin
        latch_d = latch_q;
        if (bus_req.req && bus_req.wr && bus_req.addr == pomg_pkg::POMG_ADDR_DATA_LATCH) begin
            latch_d = bus_req.wdata;
        end
    end
    always_ff @(posedge clk) begin
        latch_q <= rst ? 8'h00 : latch_d;
    end
    a_read_answers: assert property (rd |=> bus_rvalid_q) else $error("read got no valid pulse");
    a_rmw_latch: assert property (rd && bus_req.rmw && bus_req.addr == pomg_pkg::POMG_ADDR_DATA_LATCH
        |=> bus_rdata_q == $past(latch_q)) else $error("rmw read not latch");
    a_pull_input_only: assert property ((pull_up_q & pin_oe_q) == 8'h00) else $error("pull-up on driven pin");
    a_od_release: assert property ((pin_oe_q & pin_out_q & OPEN_DRAIN_OPT) == 8'h00)
        else $error("open-drain pin driven high");
    a_freeze_hold: assert property (low_power && $past(low_power)
        |-> $stable(pin_out_q) && $stable(pin_oe_q) && $stable(pull_up_q)) else $error("pins moved in low power");
    a_rx_one_hold: assert property (!periph.serial_unit_one_active
        |=> $stable(periph_in_q.serial_unit_one_rx)) else $error("idle receive input moved");
    a_rx_zero_follow: assert property ((periph.serial_unit_zero_active && $stable(pin_in[1]))[*8]
        |-> periph_in_q.serial_unit_zero_rx == pin_in[1]) else $error("receive input not pin 1");
    a_reset_clear: assert property (disable iff (1'b0) rst |=> (pin_oe_q | pull_up_q | pin_out_q) == 8'h00)
        else $error("outputs not cleared by reset");
    c_rmw: cover property (rd && bus_req.rmw);
    c_freeze: cover property (low_power [*3]);
    c_rx_zero: cover property (periph.serial_unit_zero_active && periph_in_q.serial_unit_zero_rx);
endmodule // pomg_port_props

// File: sim/pomg_pin_model.sv
// Pads and outside world of the port: resolves each pin from the block, the outside driver and the pull-up.
`timescale 1ns/1ns
module pomg_pin_model (
    input wire logic        clk,
    input wire logic  [7:0] pin_out,
    input wire logic  [7:0] pin_oe,
    input wire logic  [7:0] pull_up,
    input wire logic  [7:0] ext_val,
    input wire logic  [7:0] ext_en,
    output logic      [7:0] pin_level
);
    // An undriven pin with no pull-up wiggles, so no test can pass by reading a stale level.
    logic [7:0] wiggle_q = 8'h55;
    always_ff @(posedge clk) begin
        wiggle_q <= ~wiggle_q;
    end
    assign pin_level = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val) | (~pin_oe & ~ext_en & (pull_up | wiggle_q));
endmodule // pomg_pin_model

// File: sim/testbench.sv
// Self-checking bench of the port one multiplexed GPIO block.
`timescale 1ns/1ns
module testbench;
    localparam logic [7:0] OD = 8'h05;
    logic                        clk;
    logic                        rst;
    logic                        low_power;
    logic [7:0]                  rdata, pin_in, pin_out, pin_oe, pull_up, ext_val, ext_en;
    logic                        rvalid;
    pomg_pkg::pomg_bus_req_s     bus_req;
    pomg_pkg::pomg_periph_s      periph;
    pomg_pkg::pomg_periph_in_s   periph_in;
    int                          bad_count = 0;
    int                          checks_done = 0;
    logic [8:0]                  pats [4] = '{9'h000, 9'h1F6, 9'h114, 9'h0E2};
    pomg_port #(.WIDTH(8), .OPEN_DRAIN_OPT(OD)) u_dut (.clk(clk), .rst(rst), .bus_req(bus_req),
        .bus_rdata_q(rdata), .bus_rvalid_q(rvalid), .periph(periph), .periph_in_q(periph_in),
        .low_power(low_power), .pin_in(pin_in), .pin_out_q(pin_out), .pin_oe_q(pin_oe), .pull_up_q(pull_up));
    pomg_pin_model u_pins (.clk(clk), .pin_out(pin_out), .pin_oe(pin_oe), .pull_up(pull_up),
        .ext_val(ext_val), .ext_en(ext_en), .pin_level(pin_in));
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    task automatic conclude;
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic [15:0] a, input logic w, input logic m, input logic [7:0] d);
        @(posedge clk);
        #1;
        bus_req = '{req: 1'b1, wr: w, rmw: m, addr: a, wdata: d};
        @(posedge clk);
        #1;
        bus_req.req = 1'b0;
    endtask
    task automatic rd(input logic [15:0] a, input logic m, input logic [7:0] exp);
        bus(a, 1'b0, m, 8'h00);
        chk({7'h00, rvalid}, 8'h01);
        chk(rdata, exp);
    endtask
    task automatic cfg(input logic [7:0] l, input logic [7:0] d, input logic [7:0] f);
        bus(pomg_pkg::POMG_ADDR_DATA_LATCH, 1'b1, 1'b0, l);
        bus(pomg_pkg::POMG_ADDR_DIRECTION, 1'b1, 1'b0, d);
        bus(pomg_pkg::POMG_ADDR_FUNCTION, 1'b1, 1'b0, f);
        repeat (6) @(posedge clk);
        #1;
    endtask
    function automatic logic [7:0] merge(input logic [7:0] l, input logic [8:0] p);
        merge = {(p[8] & p[6]) ^ l[7], p[7] ^ l[6], p[5] | l[5], p[4] | l[4], p[4] | l[3], p[2] | l[2],
                 p[1] | l[1], p[1] | l[0]};
    endfunction
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset;
        rd(pomg_pkg::POMG_ADDR_DIRECTION, 1'b0, 8'h00);
        rd(pomg_pkg::POMG_ADDR_FUNCTION, 1'b0, 8'h00);
        rd(pomg_pkg::POMG_ADDR_DATA_LATCH, 1'b1, 8'h00);
        chk(pull_up, 8'h00);
    endtask
    task automatic t_drive;
        ext_val = 8'h5A;
        ext_en = 8'hFF;
        cfg(8'hA5, 8'hFF, 8'h00);
        chk(pin_out, 8'hA5);
        chk(pin_oe, 8'hFA);
        // Released open-drain bits read what the outside drives, the rest read the driven latch.
        rd(pomg_pkg::POMG_ADDR_DATA_LATCH, 1'b0, 8'hA0);
        rd(pomg_pkg::POMG_ADDR_DATA_LATCH, 1'b1, 8'hA5);
    endtask
    task automatic t_input;
        ext_val = 8'h81;
        ext_en = 8'hA5;
        cfg(8'h5A, 8'h00, 8'hFF);
        chk(pull_up, 8'h5A);
        chk(pin_oe, 8'h00);
        rd(pomg_pkg::POMG_ADDR_DATA_LATCH, 1'b0, 8'hDB);
        rd(pomg_pkg::POMG_ADDR_DATA_LATCH, 1'b1, 8'h5A);
    endtask
    task automatic t_merge;
        logic [7:0] l;
        for (int k = 0; k < 2; k++) begin
            l = k ? 8'hFF : 8'h00;
            cfg(l, 8'hFF, 8'hFF);
            foreach (pats[i]) begin
                periph = pomg_pkg::pomg_periph_s'(pats[i]);
                repeat (3) @(posedge clk);
                #1;
                chk(pin_out, merge(l, pats[i]));
                chk(pin_oe, ~(OD & merge(l, pats[i])));
            end
        end
    endtask
    task automatic t_freeze;
        cfg(8'h0F, 8'hFF, 8'h00);
        low_power = 1'b1;
        cfg(8'hF0, 8'h00, 8'h00);
        chk(pin_out, 8'h0F);
        chk(pin_oe, 8'hFA);
        chk(pull_up, 8'h00);
        low_power = 1'b0;
        cfg(8'hF0, 8'h00, 8'h00);
        chk(pull_up, 8'hF0);
    endtask
    task automatic t_rx;
        ext_en = 8'h00;
        periph = pomg_pkg::pomg_periph_s'(9'h009);
        cfg(8'h10, 8'hFF, 8'h00);
        chk({6'h00, periph_in}, 8'h02);
        periph = pomg_pkg::pomg_periph_s'(9'h001);
        cfg(8'h02, 8'hFF, 8'h00);
        chk({6'h00, periph_in}, 8'h03);
        ext_val = 8'h00;
        ext_en = 8'hFF;
        periph = pomg_pkg::pomg_periph_s'(9'h009);
        cfg(8'h00, 8'h00, 8'h00);
        chk({6'h00, periph_in}, 8'h00);
    endtask
    task automatic t_misc;
        bus(pomg_pkg::POMG_ADDR_TEST_MISC, 1'b1, 1'b0, 8'h7E);
        rd(pomg_pkg::POMG_ADDR_TEST_MISC, 1'b0, 8'h08);
        bus(16'hfe48, 1'b1, 1'b0, 8'hFF);
        rd(16'hfe48, 1'b0, 8'h00);
    endtask
    initial begin
        #200000;
        bad_count++;
        conclude();
    end
    initial begin
        rst = 1'b1;
        low_power = 1'b0;
        bus_req = '0;
        periph = '0;
        ext_val = 8'h00;
        ext_en = 8'hFF;
        repeat (8) @(posedge clk);
        #1;
        rst = 1'b0;
        t_reset();
        t_drive();
        t_input();
        t_merge();
        t_freeze();
        t_rx();
        t_misc();
        conclude();
    end
endmodule // testbench
bind pomg_port pomg_port_props #(.WIDTH(WIDTH), .OPEN_DRAIN_OPT(OPEN_DRAIN_OPT)) u_props (.clk(clk), .rst(rst),
    .bus_req(bus_req), .bus_rdata_q(bus_rdata_q), .bus_rvalid_q(bus_rvalid_q), .periph(periph),
    .periph_in_q(periph_in_q), .low_power(low_power), .pin_in(pin_in), .pin_out_q(pin_out_q),
    .pin_oe_q(pin_oe_q), .pull_up_q(pull_up_q));
